// ---- inc/i2c_slave_pkg.sv ----
package i2c_slave_pkg;
	// register word offsets (byte addresses on the APB side)
	localparam logic [7:0] OFS_CONTROL = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_ADDRESS = 8'h08;
	localparam logic [7:0] OFS_TX_HOLD = 8'h0C;
	localparam logic [7:0] OFS_RX_HOLD = 8'h10;

	// bus_control fields
	localparam int CTL_MODULE_ON = 15;
	localparam int CTL_CLOCK_RELEASE = 12;
	localparam int CTL_TEN_BIT_MODE = 10;
	localparam int CTL_STRETCH_EN = 6;
	localparam logic [15:0] CONTROL_RESET = 16'h1000;

	// bus_status fields; bits below STAT_RO_BITS are read-only
	localparam int STAT_RX_FULL = 0;
	localparam int STAT_TX_FULL = 1;
	localparam int STAT_DIR_READ = 2;
	localparam int STAT_TEN_MATCH = 3;
	localparam int STAT_MASTER_NACK = 4;
	localparam int STAT_RO_BITS = 6;
	localparam int STAT_OVERFLOW = 6;
	localparam int STAT_EVENT = 7;
	localparam logic [9:0] STATUS_HI_RESET = 10'h000;

	localparam logic [9:0] ADDRESS_RESET = 10'h000;
	localparam logic [4:0] TEN_BIT_PREFIX = 5'h1E;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ADDR,
		ST_ADDR2,
		ST_RX,
		ST_TX
	} slv_state_e;

	// complete state of the engine, registered as one word
	typedef struct packed {
		logic scl_m;
		logic sda_m;
		logic scl_s;
		logic sda_s;
		logic scl_p;
		logic sda_p;
		slv_state_e state;
		slv_state_e pend_st;
		logic [3:0] cnt;
		logic [7:0] sh;
		logic ack_ph;
		logic pend_evt;
		logic tx_loaded;
		logic dir;
		logic ten_match;
		logic master_nack;
		logic rx_buffer_full_flag;
		logic tx_buffer_full_flag;
		logic [15:0] ctrl;
		logic [9:0] stat_hi;
		logic [9:0] addr;
		logic [7:0] txh;
		logic [7:0] rxb;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic scl_oe_n;
		logic sda_oe_n;
		logic event_p;
	} slv_st_s;
endpackage

// ---- core/i2c_slave_engine.sv ----
// Decided for this implementation: the APB register port and the placing of the registers.
`timescale 1ns/1ps
// Behaviour
// [RULE1] 7-bit mode: own address 6..0 against byte bits 7..1, bit 0 is direction.
// [RULE2] ten-bit mode bit 10 of control picks 10-bit address interpretation.
// [RULE3] serial data bits sampled on rising serial clock edges.
// [RULE4] address match: acknowledge, event flag on falling edge of ninth clock.
// [RULE5] address byte leaves rx buffer and its full flag untouched.
// [RULE6] read direction: ack, hold clock low until release, shift 8 bits out.
// [RULE7] transmit: event pulse on ninth falling edge whatever the master acked.
// [RULE8] receive: load buffer if not full and no overflow, then acknowledge.
// [RULE9] buffer still full: no ack, no load, event pulse still given.
// [RULE10] overflow set but buffer empty: load byte but answer not-acknowledge.
// [RULE11] 10-bit first byte 11110+A9A8 write: event, clear ten-bit match flag.
// [RULE12] first 10-bit byte mismatch or read: clear match flag, go idle.
// [RULE13] second 10-bit byte vs address 7..0: set flag and event, else idle.
// [RULE14] repeated start after full 10-bit match needs only first byte.
// [RULE15] receive double-buffered with event per byte; transmit single stage (code frees tx hold as each byte starts, so the next can be preloaded).
// [RULE16] transmit always stretches the clock, stretch enable ignored.
// [RULE17] ninth fall, ack seen, tx buffer empty: clear clock release.
// [RULE18] tx buffer loaded before ninth fall: no release clear, no stretch.
// [RULE19] software may set clock release any time; clock low until set.
// [RULE20] status low six bits read-only, rest read/write; control all RW (code ignores software clears of clock release while stretch enable is off).
// [RULE21] own address register holds 10 bits for both modes.
// [RULE22] both lines open-drain; clock released, never driven high.
module i2c_slave_engine #(
	parameter int AW = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic scl_i,
	output logic scl_o,
	output logic scl_oe_n,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_n,
	output logic slave_event
);
	i2c_slave_pkg::slv_st_s s_r, s_nxt;
	logic line_rise, line_fall, bus_start, bus_stop;
	logic acc, wr, rd;
	logic [7:0] woff;
	logic [15:0] stat_word;

	// line events from the synchronised copies only
	assign line_rise = s_r.scl_s && !s_r.scl_p;
	assign line_fall = !s_r.scl_s && s_r.scl_p;
	assign bus_start = s_r.scl_s && s_r.scl_p && !s_r.sda_s && s_r.sda_p;
	assign bus_stop = s_r.scl_s && s_r.scl_p && s_r.sda_s && !s_r.sda_p;

	// access edge: the one edge where writes land and reads take effect
	assign acc = psel && penable && s_r.pready;
	assign wr = acc && pwrite;
	assign rd = acc && !pwrite;
	assign woff = 8'(paddr);

	assign stat_word = {s_r.stat_hi, 1'b0, s_r.master_nack, s_r.ten_match,
		s_r.dir, s_r.tx_buffer_full_flag, s_r.rx_buffer_full_flag};

	always_comb begin
		s_nxt = s_r;
		// two-flop synchronisers, then one more stage for edges
		s_nxt.scl_m = scl_i;
		s_nxt.sda_m = sda_i;
		s_nxt.scl_s = s_r.scl_m;
		s_nxt.sda_s = s_r.sda_m;
		s_nxt.scl_p = s_r.scl_s;
		s_nxt.sda_p = s_r.sda_s;
		s_nxt.event_p = 1'b0;
		s_nxt.pready = 1'b0;
		s_nxt.pslverr = 1'b0;

		// setup cycle: decode and register the answer for the access phase
		if (psel && !penable) begin
			s_nxt.pready = 1'b1;
			s_nxt.prdata = 32'h00000000;
			unique case (woff)
				i2c_slave_pkg::OFS_CONTROL: s_nxt.prdata = 32'(s_r.ctrl);
				i2c_slave_pkg::OFS_STATUS: s_nxt.prdata = 32'(stat_word);
				i2c_slave_pkg::OFS_ADDRESS: s_nxt.prdata = 32'(s_r.addr);
				i2c_slave_pkg::OFS_TX_HOLD: s_nxt.prdata = 32'(s_r.txh);
				i2c_slave_pkg::OFS_RX_HOLD: s_nxt.prdata = 32'(s_r.rxb);
				default: s_nxt.pslverr = 1'b1;
			endcase
		end

		// software writes; hardware events below override flag clears
		if (wr && woff == i2c_slave_pkg::OFS_CONTROL) begin
			// [RULE20] control writable, but release clears only with stretch on
			s_nxt.ctrl = pwdata[15:0];
			// [RULE19] release can always be set, cleared only with stretch on
			if (!pwdata[i2c_slave_pkg::CTL_CLOCK_RELEASE] &&
				!s_r.ctrl[i2c_slave_pkg::CTL_STRETCH_EN])
				s_nxt.ctrl[i2c_slave_pkg::CTL_CLOCK_RELEASE] =
					s_r.ctrl[i2c_slave_pkg::CTL_CLOCK_RELEASE];
		end
		// [RULE20] only the upper status bits take writes
		if (wr && woff == i2c_slave_pkg::OFS_STATUS)
			s_nxt.stat_hi = pwdata[15:i2c_slave_pkg::STAT_RO_BITS];
		// [RULE21] full ten-bit own address
		if (wr && woff == i2c_slave_pkg::OFS_ADDRESS)
			s_nxt.addr = pwdata[9:0];
		if (wr && woff == i2c_slave_pkg::OFS_TX_HOLD)
			s_nxt.txh = pwdata[7:0];
		// reading the receive buffer empties it
		if (rd && woff == i2c_slave_pkg::OFS_RX_HOLD)
			s_nxt.rx_buffer_full_flag = 1'b0;

		// serial engine
		if (!s_r.ctrl[i2c_slave_pkg::CTL_MODULE_ON] || bus_stop) begin
			s_nxt.state = i2c_slave_pkg::ST_IDLE;
			s_nxt.ack_ph = 1'b0;
			s_nxt.sda_oe_n = 1'b1;
		end else if (bus_start) begin
			// a repeated start keeps the ten-bit match flag
			s_nxt.state = i2c_slave_pkg::ST_ADDR;
			s_nxt.cnt = 4'h0;
			s_nxt.ack_ph = 1'b0;
			s_nxt.sda_oe_n = 1'b1;
		end else begin
			unique case (s_r.state)
				i2c_slave_pkg::ST_IDLE: begin
					s_nxt.sda_oe_n = 1'b1;
				end
				i2c_slave_pkg::ST_ADDR, i2c_slave_pkg::ST_ADDR2,
				i2c_slave_pkg::ST_RX: begin
					if (s_r.ack_ph) begin
						// [RULE4] end of ninth clock: release data, flag event
						if (line_fall) begin
							s_nxt.ack_ph = 1'b0;
							s_nxt.sda_oe_n = 1'b1;
							s_nxt.cnt = 4'h0;
							s_nxt.state = s_r.pend_st;
							s_nxt.event_p = s_r.pend_evt;
							s_nxt.tx_loaded = 1'b0;
							// [RULE6] enter transmit stretched unless data waits
							if (s_r.pend_st == i2c_slave_pkg::ST_TX && !s_r.tx_buffer_full_flag)
								s_nxt.ctrl[i2c_slave_pkg::CTL_CLOCK_RELEASE] = 1'b0;
						end
					end else if (line_rise &&
						s_r.cnt < i2c_slave_pkg::BITS_PER_BYTE) begin
						// [RULE3] shift in on rising clock
						s_nxt.sh = {s_r.sh[6:0], s_r.sda_s};
						s_nxt.cnt = s_r.cnt + 4'h1;
					end else if (line_fall &&
						s_r.cnt == i2c_slave_pkg::BITS_PER_BYTE) begin
						// byte complete: decide ack, next state and event
						s_nxt.ack_ph = 1'b1;
						s_nxt.pend_evt = 1'b0;
						s_nxt.pend_st = i2c_slave_pkg::ST_IDLE;
						s_nxt.sda_oe_n = 1'b1;
						if (s_r.state == i2c_slave_pkg::ST_ADDR &&
							!s_r.ctrl[i2c_slave_pkg::CTL_TEN_BIT_MODE]) begin
							// [RULE2] 7-bit interpretation
							// [RULE1] compare and take direction bit
							// [RULE5] address byte leaves rx buffer alone
							if (s_r.sh[7:1] == s_r.addr[6:0]) begin
								s_nxt.sda_oe_n = 1'b0;
								s_nxt.pend_evt = 1'b1;
								s_nxt.dir = s_r.sh[0];
								s_nxt.pend_st = s_r.sh[0] ? i2c_slave_pkg::ST_TX
									: i2c_slave_pkg::ST_RX;
							end
						end else if (s_r.state == i2c_slave_pkg::ST_ADDR) begin
							if (s_r.sh[7:3] == i2c_slave_pkg::TEN_BIT_PREFIX &&
								s_r.sh[2:1] == s_r.addr[9:8] && !s_r.sh[0]) begin
								// [RULE11] partial match, wait for low byte
								s_nxt.sda_oe_n = 1'b0;
								s_nxt.pend_evt = 1'b1;
								s_nxt.ten_match = 1'b0;
								s_nxt.dir = 1'b0;
								s_nxt.pend_st = i2c_slave_pkg::ST_ADDR2;
							end else if (s_r.sh[7:3] ==
								i2c_slave_pkg::TEN_BIT_PREFIX &&
								s_r.sh[2:1] == s_r.addr[9:8] && s_r.ten_match) begin
								// [RULE14] earlier full match: first byte enough
								s_nxt.sda_oe_n = 1'b0;
								s_nxt.pend_evt = 1'b1;
								s_nxt.dir = 1'b1;
								s_nxt.pend_st = i2c_slave_pkg::ST_TX;
							end else begin
								// [RULE12] mismatch or read: drop the match
								s_nxt.ten_match = 1'b0;
							end
						end else if (s_r.state == i2c_slave_pkg::ST_ADDR2) begin
							// [RULE13] low address byte
							if (s_r.sh == s_r.addr[7:0]) begin
								s_nxt.sda_oe_n = 1'b0;
								s_nxt.pend_evt = 1'b1;
								s_nxt.ten_match = 1'b1;
								s_nxt.pend_st = i2c_slave_pkg::ST_RX;
							end else begin
								s_nxt.ten_match = 1'b0;
							end
						end else begin
							// [RULE15] every received byte gives an event
							s_nxt.pend_evt = 1'b1;
							s_nxt.pend_st = i2c_slave_pkg::ST_RX;
							if (s_r.rx_buffer_full_flag) begin
								// [RULE9] still full: nack, keep old byte
								s_nxt.stat_hi[i2c_slave_pkg::STAT_OVERFLOW -
									i2c_slave_pkg::STAT_RO_BITS] = 1'b1;
							end else if (s_r.stat_hi[i2c_slave_pkg::STAT_OVERFLOW -
								i2c_slave_pkg::STAT_RO_BITS]) begin
								// [RULE10] stale overflow: load yet nack
								s_nxt.rxb = s_r.sh;
								s_nxt.rx_buffer_full_flag = 1'b1;
							end else begin
								// [RULE8] load buffer and acknowledge
								s_nxt.rxb = s_r.sh;
								s_nxt.rx_buffer_full_flag = 1'b1;
								s_nxt.sda_oe_n = 1'b0;
							end
						end
					end
				end
				i2c_slave_pkg::ST_TX: begin
					if (s_r.ack_ph) begin
						if (line_rise)
							s_nxt.master_nack = s_r.sda_s;
						if (line_fall) begin
							// [RULE7] event regardless of master ack
							s_nxt.event_p = 1'b1;
							s_nxt.ack_ph = 1'b0;
							s_nxt.tx_loaded = 1'b0;
							s_nxt.cnt = 4'h0;
							if (s_r.master_nack)
								s_nxt.state = i2c_slave_pkg::ST_IDLE;
							// [RULE17] ack and empty buffer: stretch
							// [RULE18] data already loaded: no stretch
							else if (!s_r.tx_buffer_full_flag)
								s_nxt.ctrl[i2c_slave_pkg::CTL_CLOCK_RELEASE] = 1'b0;
						end
					end else if (!s_r.tx_loaded) begin
						// [RULE6] first bit goes out once clock is released
						if (s_r.ctrl[i2c_slave_pkg::CTL_CLOCK_RELEASE] &&
							!s_r.scl_s) begin
							s_nxt.sh = s_r.txh;
							s_nxt.tx_buffer_full_flag = 1'b0;
							s_nxt.tx_loaded = 1'b1;
							s_nxt.sda_oe_n = s_r.txh[7];
						end
					end else begin
						if (line_rise)
							s_nxt.cnt = s_r.cnt + 4'h1;
						if (line_fall) begin
							// [RULE6] next bit changes on the falling edge
							if (s_r.cnt == i2c_slave_pkg::BITS_PER_BYTE) begin
								s_nxt.sda_oe_n = 1'b1;
								s_nxt.ack_ph = 1'b1;
							end else begin
								s_nxt.sh = {s_r.sh[6:0], 1'b0};
								s_nxt.sda_oe_n = s_r.sh[6];
							end
						end
					end
				end
			endcase
		end

		// hardware set wins over a software clear in the same cycle
		if (s_nxt.event_p)
			s_nxt.stat_hi[i2c_slave_pkg::STAT_EVENT -
				i2c_slave_pkg::STAT_RO_BITS] = 1'b1;
		// a write in the load cycle must not be lost
		if (wr && woff == i2c_slave_pkg::OFS_TX_HOLD)
			s_nxt.tx_buffer_full_flag = 1'b1;
		// [RULE16] transmit stretch ignores the stretch enable bit
		// [RULE22] clock only ever pulled low, never driven high
		// once stretched, keep the clock low until the first bit has settled
		// for a cycle, else the data line would move with the clock high
		s_nxt.scl_oe_n = !(s_nxt.state == i2c_slave_pkg::ST_TX &&
			(!s_nxt.ctrl[i2c_slave_pkg::CTL_CLOCK_RELEASE] ||
			(!s_r.tx_loaded && !s_r.ack_ph && !s_r.scl_oe_n)));
	end

	// one register for the whole state; constants only under reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_r <= '0;
			s_r.scl_m <= 1'b1;
			s_r.sda_m <= 1'b1;
			s_r.scl_s <= 1'b1;
			s_r.sda_s <= 1'b1;
			s_r.scl_p <= 1'b1;
			s_r.sda_p <= 1'b1;
			s_r.state <= i2c_slave_pkg::ST_IDLE;
			s_r.pend_st <= i2c_slave_pkg::ST_IDLE;
			s_r.ctrl <= i2c_slave_pkg::CONTROL_RESET;
			s_r.stat_hi <= i2c_slave_pkg::STATUS_HI_RESET;
			s_r.addr <= i2c_slave_pkg::ADDRESS_RESET;
			s_r.scl_oe_n <= 1'b1;
			s_r.sda_oe_n <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	// open-drain: the output level is a constant low held in a flop
	logic pin_low_r;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			pin_low_r <= 1'b0;
		else
			pin_low_r <= 1'b0;
	end

	assign prdata = s_r.prdata;
	assign pready = s_r.pready;
	assign pslverr = s_r.pslverr;
	assign scl_o = pin_low_r;
	assign sda_o = pin_low_r;
	assign scl_oe_n = s_r.scl_oe_n;
	assign sda_oe_n = s_r.sda_oe_n;
	assign slave_event = s_r.event_p;
endmodule

// ---- verification/i2c_slave_engine_chk.sv ----
`timescale 1ns/1ps
module i2c_slave_engine_chk #(
	parameter int AW = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic scl_i,
	input wire logic scl_o,
	input wire logic scl_oe_n,
	input wire logic sda_i,
	input wire logic sda_o,
	input wire logic sda_oe_n,
	input wire logic slave_event
);
	// software write that sets the clock release bit
	wire rel = psel & penable & pready & pwrite &
		paddr[7:0] == i2c_slave_pkg::OFS_CONTROL &
		pwdata[i2c_slave_pkg::CTL_CLOCK_RELEASE];
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	chk_lines_low:
	assert property (!scl_o && !sda_o) else $error("line driven high");
	chk_event_once:
	assert property (slave_event |=> !slave_event) else $error("long event");
	chk_event_edge:
	assert property (slave_event |-> !scl_i && sda_oe_n)
		else $error("event off the ninth fall");
	chk_stretch_fall:
	assert property ($fell(scl_oe_n) |-> !scl_i)
		else $error("stretch while clock high");
	// the clock is let go two edges after the release write
	chk_stretch_hold:
	assert property (!scl_oe_n && !rel && !$past(rel) && !$past(rel, 2)
		|=> !scl_oe_n) else $error("clock freed without release");
	chk_release_now:
	assert property (rel |-> ##[1:3] scl_oe_n) else $error("clock kept low");
	chk_sda_in_low:
	assert property ($changed(sda_oe_n) |-> !scl_i)
		else $error("data moved while clock high");
	chk_unmapped_err:
	assert property (psel && !penable && paddr[7:0] > 8'h10 |=>
		pslverr && prdata == 32'h0) else $error("unmapped not refused");
	cover property (slave_event);
	cover property ($fell(scl_oe_n));
	cover property (pslverr);
endmodule
bind i2c_slave_engine i2c_slave_engine_chk #(.AW(AW)) u_chk (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .scl_i(scl_i), .scl_o(scl_o),
	.scl_oe_n(scl_oe_n), .sda_i(sda_i), .sda_o(sda_o),
	.sda_oe_n(sda_oe_n), .slave_event(slave_event));

// ---- verification/i2c_bus_master_model.sv ----
`timescale 1ns/1ps
// far-side master; its clock stands still between frames
module i2c_bus_master_model (
	input wire logic scl_w,
	input wire logic sda_w,
	output logic scl_m,
	output logic sda_m
);
	localparam realtime Q = 31.25;
	// lines released until the first frame
	initial begin
		scl_m = 1'b1;
		sda_m = 1'b1;
	end
	// one clock; cond makes it a start (b=1) or a stop (b=0)
	task automatic clk(input logic b, input logic cond, output logic s);
		#Q;
		sda_m = b;
		#Q;
		scl_m = 1'b1;
		// wait on the wire, so a stretching slave holds us
		wait (scl_w === 1'b1);
		#Q;
		s = sda_w;
		if (cond)
			sda_m = ~b;
		#Q;
		if (!cond || b)
			scl_m = 1'b0;
	endtask
	// eight bits msb first, then the acknowledge clock
	task automatic xfer(input logic [7:0] d, input logic ain,
		output logic [7:0] q, output logic aout);
		for (int i = 7; i >= 0; i--)
			clk(d[i], 1'b0, q[i]);
		clk(ain, 1'b0, aout);
	endtask
endmodule

// ---- verification/tb.sv ----
`timescale 1ns/1ps
module tb;
	localparam logic [7:0] A_CTL = i2c_slave_pkg::OFS_CONTROL;
	localparam logic [7:0] A_STA = i2c_slave_pkg::OFS_STATUS;
	localparam logic [7:0] A_TX = i2c_slave_pkg::OFS_TX_HOLD;
	localparam logic [7:0] A_RX = i2c_slave_pkg::OFS_RX_HOLD;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, ack;
	logic scl_o, sda_o, scl_oe_n, sda_oe_n, slave_event, scl_m, sda_m;
	logic [7:0] paddr, q, d1, d2, t1, t2;
	logic [31:0] pwdata, prdata, rd, ctl;
	logic [9:0] a;
	int seed = int'(32'hCF62BC82);
	int miscompares, checks_done, cyc, events, stretches, e0, s0;
	// pull-ups: a line is low while any party pulls it
	wire scl_w = scl_m & (scl_oe_n | scl_o);
	wire sda_w = sda_m & (sda_oe_n | sda_o);
	i2c_slave_engine dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_i(scl_w),
		.scl_o(scl_o), .scl_oe_n(scl_oe_n), .sda_i(sda_w), .sda_o(sda_o),
		.sda_oe_n(sda_oe_n), .slave_event(slave_event));
	i2c_bus_master_model m (.scl_w(scl_w), .sda_w(sda_w), .scl_m(scl_m),
		.sda_m(sda_m));
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	// event and stretch counts, plus the hang guard
	always @(posedge pclk) begin
		cyc++;
		if (slave_event === 1'b1)
			events++;
		if ($fell(scl_oe_n))
			stretches++;
		if (cyc == 20000) begin
			miscompares++;
			report_and_stop;
		end
	end
	task automatic apb(input logic w, input logic [7:0] ad,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= ad;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// wait as long as it takes; the cycle guard ends a hang
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic cmp(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			miscompares++;
			$display("MISMATCH %s exp %h got %h", nm, e, g);
		end
	endtask
	// master reads a byte; software answers the stretch
	task automatic tx(input logic [7:0] t, input logic pre, input logic ma);
		int n;
		fork
			m.xfer(8'hFF, ma, q, ack);
			begin
				for (n = 0; n < 500 && scl_oe_n !== 1'b0; n++)
					@(posedge pclk);
				apb(1, A_TX, 32'(t));
				apb(1, A_CTL, ctl);
				if (pre)
					apb(1, A_TX, 32'(t2));
			end
		join
		cmp("tx byte", 32'(t), 32'(q));
	endtask
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		{presetn, psel, penable, pwrite} = 4'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		a = 10'($random(seed));
		d1 = 8'($random(seed));
		d2 = ~d1;
		t1 = 8'($random(seed));
		t2 = ~t1;
		apb(0, A_CTL, 0);
		cmp("ctl", 32'(i2c_slave_pkg::CONTROL_RESET), rd);
		apb(1, A_CTL, 0);
		apb(0, A_CTL, 0);
		cmp("rel kept", 32'(i2c_slave_pkg::CONTROL_RESET), rd);
		apb(1, A_CTL, 32'h0040);
		apb(1, A_CTL, 32'h0040);
		apb(0, A_CTL, 0);
		cmp("rel clear", 32'h0040, rd);
		apb(1, A_STA, 32'hFFFF);
		apb(0, A_STA, 0);
		cmp("status", 32'hFFC0, rd);
		apb(1, A_STA, 0);
		apb(1, i2c_slave_pkg::OFS_ADDRESS, 32'(a));
		apb(0, i2c_slave_pkg::OFS_ADDRESS, 0);
		cmp("addr", 32'(a), rd);
		apb(0, 8'h14, 0);
		cmp("unmapped", 1, 32'(err));
		$display("test regs done");
		ctl = 32'h9000; // module on, clock released
		apb(1, A_CTL, ctl);
		m.clk(1'b1, 1'b1, ack);
		m.xfer({a[6:0] ^ 7'h01, 1'b0}, 1'b1, q, ack);
		cmp("foreign", 1, 32'(ack));
		m.clk(1'b0, 1'b1, ack);
		e0 = events;
		m.clk(1'b1, 1'b1, ack);
		m.xfer({a[6:0], 1'b0}, 1'b1, q, ack);
		cmp("own", 0, 32'(ack));
		apb(0, A_STA, 0);
		cmp("rbf", 0, 32'(rd[0]));
		m.xfer(d1, 1'b1, q, ack);
		cmp("d1 ack", 0, 32'(ack));
		m.xfer(d2, 1'b1, q, ack);
		cmp("full ack", 1, 32'(ack));
		apb(0, A_RX, 0);
		cmp("rx d1", 32'(d1), rd);
		m.xfer(t1, 1'b1, q, ack);
		cmp("ovf ack", 1, 32'(ack));
		apb(0, A_RX, 0);
		cmp("rx ovf", 32'(t1), rd);
		m.clk(1'b0, 1'b1, ack);
		cmp("events", 32'(e0 + 4), 32'(events));
		apb(1, A_STA, 0);
		$display("test rx done");
		e0 = events;
		s0 = stretches;
		m.clk(1'b1, 1'b1, ack);
		m.xfer({a[6:0], 1'b1}, 1'b1, q, ack);
		tx(t1, 1'b1, 1'b0);
		m.xfer(8'hFF, 1'b0, q, ack);
		cmp("preload", 32'(t2), 32'(q));
		tx(t1, 1'b0, 1'b1);
		m.clk(1'b0, 1'b1, ack);
		cmp("stretch", 32'(s0 + 2), 32'(stretches));
		cmp("tx events", 32'(e0 + 4), 32'(events));
		$display("test tx done");
		ctl = 32'h9400; // ten-bit addressing on
		apb(1, A_CTL, ctl);
		m.clk(1'b1, 1'b1, ack);
		m.xfer({5'h1E, a[9:8], 1'b0}, 1'b1, q, ack);
		apb(0, A_STA, 0);
		cmp("hdr", 32'h0, {30'h0, rd[3], ack});
		m.xfer(a[7:0], 1'b1, q, ack);
		apb(0, A_STA, 0);
		cmp("low", 32'h2, {30'h0, rd[3], ack});
		m.clk(1'b1, 1'b1, ack);
		m.xfer({5'h1E, a[9:8], 1'b1}, 1'b1, q, ack);
		cmp("restart", 0, 32'(ack));
		tx(t2, 1'b0, 1'b1);
		m.clk(1'b0, 1'b1, ack);
		m.clk(1'b1, 1'b1, ack);
		m.xfer({5'h1E, ~a[9:8], 1'b0}, 1'b1, q, ack);
		apb(0, A_STA, 0);
		cmp("bad hdr", 32'h1, {30'h0, rd[3], ack});
		m.clk(1'b0, 1'b1, ack);
		$display("test ten done");
		report_and_stop;
	end
endmodule
